// ===== rtl/acd_regs.sv
// Functional notes
// - activity clock source from 0x20 bits 7-6: osc, bit clock, secondary, custom.
// - bits 5-4 give external clock: 24.576, 6.144, 12.288, 18.432 MHz.
// - bit 2 of 0x20 enables phase-one detection via jack comparator.
// - limiter detector: max, channel one, channel zero, or average of both.
// - limiter gain applied to both, channel one, channel zero, or neither.
// - 0x24 bits 7-4 enable auto gain on channels one to four.
// - 0x24 bits 3-0 enable compression on channels one to four.
// - all four registers reset to 0x00.
// - supply attenuation from pin and field, or lookup on analog voltage.
// - recovery bit allows attenuation to fall; otherwise hold or increase.
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"

module acd_regs #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register access
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // activity detection clocking
  output acd_pkg::acd_clk_src_t ACT_CLK_SOURCE,
  output logic ACT_CLK_USE_OSC,
  output logic ACT_CLK_USE_BITCLK,
  output logic ACT_CLK_USE_SECONDARY,
  output logic ACT_CLK_USE_CUSTOM,
  output logic [14:0] ACT_EXT_CLK_KHZ,
  // phase-one detection
  input wire logic JACK_COMPARATOR,
  output logic PHASE_ONE_DETECT_ENABLE,
  output logic PHASE_ONE_TRIGGER,
  // limiter routing
  input wire logic SAMPLE_VALID,
  input wire logic signed [SAMPLE_W-1:0] DAC_INPUT_CHANNEL_ZERO,
  input wire logic signed [SAMPLE_W-1:0] DAC_INPUT_CHANNEL_ONE,
  output logic signed [SAMPLE_W-1:0] LIMITER_DETECT_SAMPLE,
  output logic LIMITER_DETECT_VALID,
  output logic LIMITER_APPLY_CH0,
  output logic LIMITER_APPLY_CH1,
  // channel dynamics enables
  output logic [3:0] AUTO_GAIN_CHANNEL_ENABLE,
  output logic [3:0] COMPRESSOR_CHANNEL_ENABLE,
  // supply limiter
  input wire logic GPIO_LOW_SUPPLY,
  input wire logic [`ACD_SAR_W-1:0] SAR_DATA,
  input wire logic SAR_VALID,
  output logic SUPPLY_LIMITER_ENABLE,
  output logic [2:0] SUPPLY_LIMITER_ATTENUATION
);

  // ********************************
  // register storage
  // ********************************
  logic [7:0] activity_clock_config;
  logic [7:0] limiter_routing_config;
  logic [7:0] gain_compression_channel_enables;
  logic [7:0] supply_limiter_config_0;
  logic [7:0] next_rdata;
  acd_pkg::acd_det_src_t det_src;
  acd_pkg::acd_app_sel_t app_sel;
  acd_pkg::acd_plim_cfg_t plim_cfg;
  acd_pkg::acd_chan_en_t chan_en;
  logic signed [SAMPLE_W:0] pair_sum;
  logic signed [SAMPLE_W-1:0] next_detect;

  // writes are masked so reserved bits never store a one
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      activity_clock_config <= `ACD_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `ACD_ADDR_ACT_CLK) begin
      activity_clock_config <= REG_WDATA & `ACD_MASK_ACT_CLK;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      limiter_routing_config <= `ACD_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `ACD_ADDR_LIM_ROUTE) begin
      limiter_routing_config <= REG_WDATA & `ACD_MASK_LIM_ROUTE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gain_compression_channel_enables <= `ACD_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `ACD_ADDR_GAIN_COMP) begin
      gain_compression_channel_enables <= REG_WDATA & `ACD_MASK_GAIN_COMP;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      supply_limiter_config_0 <= `ACD_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `ACD_ADDR_PLIM0) begin
      supply_limiter_config_0 <= REG_WDATA & `ACD_MASK_PLIM0;
    end
  end

  // ********************************
  // read port
  // ********************************
  // unmapped addresses read zero rather than stale data
  always_comb begin
    unique case (REG_ADDR)
      `ACD_ADDR_ACT_CLK: next_rdata = activity_clock_config;
      `ACD_ADDR_LIM_ROUTE: next_rdata = limiter_routing_config;
      `ACD_ADDR_GAIN_COMP: next_rdata = gain_compression_channel_enables;
      `ACD_ADDR_PLIM0: next_rdata = supply_limiter_config_0;
      default: next_rdata = `ACD_READ_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= `ACD_READ_ZERO;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
    end
  end

  // ********************************
  // activity detection clocking
  // ********************************
  assign ACT_CLK_SOURCE =
    acd_pkg::acd_clk_src_t'(activity_clock_config[`ACD_CLK_SRC_HI:`ACD_CLK_SRC_LO]);
  assign ACT_CLK_USE_OSC = (ACT_CLK_SOURCE == acd_pkg::ACD_CLK_OSC);
  assign ACT_CLK_USE_BITCLK = (ACT_CLK_SOURCE == acd_pkg::ACD_CLK_BITCLK);
  assign ACT_CLK_USE_SECONDARY = (ACT_CLK_SOURCE == acd_pkg::ACD_CLK_SECONDARY);
  assign ACT_CLK_USE_CUSTOM = (ACT_CLK_SOURCE == acd_pkg::ACD_CLK_CUSTOM);

  always_comb begin
    unique case (activity_clock_config[`ACD_EXT_RATE_HI:`ACD_EXT_RATE_LO])
      2'h0: ACT_EXT_CLK_KHZ = `ACD_EXT_KHZ_0;
      2'h1: ACT_EXT_CLK_KHZ = `ACD_EXT_KHZ_1;
      2'h2: ACT_EXT_CLK_KHZ = `ACD_EXT_KHZ_2;
      2'h3: ACT_EXT_CLK_KHZ = `ACD_EXT_KHZ_3;
    endcase
  end

  // ********************************
  // phase-one detection
  // ********************************
  assign PHASE_ONE_DETECT_ENABLE = activity_clock_config[`ACD_PH1_BIT];

  // comparator is already synchronous; gate it so a disabled path stays quiet
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PHASE_ONE_TRIGGER <= 1'b0;
    end else begin
      PHASE_ONE_TRIGGER <= PHASE_ONE_DETECT_ENABLE & JACK_COMPARATOR;
    end
  end

  // ********************************
  // limiter routing
  // ********************************
  assign det_src =
    acd_pkg::acd_det_src_t'(limiter_routing_config[`ACD_LIM_DET_HI:`ACD_LIM_DET_LO]);
  assign app_sel =
    acd_pkg::acd_app_sel_t'(limiter_routing_config[`ACD_LIM_APP_HI:`ACD_LIM_APP_LO]);
  // one extra bit keeps the average from overflowing
  assign pair_sum = DAC_INPUT_CHANNEL_ZERO + DAC_INPUT_CHANNEL_ONE;

  always_comb begin
    unique case (det_src)
      acd_pkg::ACD_DET_MAX: next_detect = (DAC_INPUT_CHANNEL_ZERO > DAC_INPUT_CHANNEL_ONE) ?
        DAC_INPUT_CHANNEL_ZERO : DAC_INPUT_CHANNEL_ONE;
      acd_pkg::ACD_DET_CH1: next_detect = DAC_INPUT_CHANNEL_ONE;
      acd_pkg::ACD_DET_CH0: next_detect = DAC_INPUT_CHANNEL_ZERO;
      acd_pkg::ACD_DET_AVG: next_detect = pair_sum[SAMPLE_W:1];
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LIMITER_DETECT_SAMPLE <= '0;
    end else if (SAMPLE_VALID) begin
      LIMITER_DETECT_SAMPLE <= next_detect;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LIMITER_DETECT_VALID <= 1'b0;
    end else begin
      LIMITER_DETECT_VALID <= SAMPLE_VALID;
    end
  end

  assign LIMITER_APPLY_CH0 = (app_sel == acd_pkg::ACD_APP_BOTH) ||
    (app_sel == acd_pkg::ACD_APP_CH0);
  assign LIMITER_APPLY_CH1 = (app_sel == acd_pkg::ACD_APP_BOTH) ||
    (app_sel == acd_pkg::ACD_APP_CH1);

  // ********************************
  // channel dynamics enables
  // ********************************
  // bit order runs channel one at the top down to channel four
  assign chan_en.auto_gain = gain_compression_channel_enables[`ACD_AGC_HI:`ACD_AGC_LO];
  assign chan_en.compressor = gain_compression_channel_enables[`ACD_DRC_HI:`ACD_DRC_LO];

  generate
    for (genvar i = 0; i < 4; i++) begin : g_chan
      assign AUTO_GAIN_CHANNEL_ENABLE[i] = chan_en.auto_gain[3-i];
      assign COMPRESSOR_CHANNEL_ENABLE[i] = chan_en.compressor[3-i];
    end
  endgenerate

  // ********************************
  // supply limiter
  // ********************************
  assign plim_cfg.enable = supply_limiter_config_0[`ACD_PLIM_EN_BIT];
  assign plim_cfg.attenuation = supply_limiter_config_0[`ACD_PLIM_ATT_HI:`ACD_PLIM_ATT_LO];
  assign plim_cfg.analog_source = supply_limiter_config_0[`ACD_PLIM_SRC_BIT];
  assign plim_cfg.recover = supply_limiter_config_0[`ACD_PLIM_REC_BIT];
  assign SUPPLY_LIMITER_ENABLE = plim_cfg.enable;

  acd_plim u_plim (
    .clk(CLK),
    .nrst(NRST),
    .cfg(plim_cfg),
    .gpio_low_supply(GPIO_LOW_SUPPLY),
    .sar_data(SAR_DATA),
    .sar_valid(SAR_VALID),
    .attenuation(SUPPLY_LIMITER_ATTENUATION)
  );

endmodule
`default_nettype wire

// ===== inc/acd_cfg.svh
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

// ********************************
// register offsets
// ********************************
`define ACD_ADDR_ACT_CLK 8'h20
`define ACD_ADDR_LIM_ROUTE 8'h23
`define ACD_ADDR_GAIN_COMP 8'h24
`define ACD_ADDR_PLIM0 8'h2B

// ********************************
// reset values and writable masks
// ********************************
`define ACD_RESET_VAL 8'h00
`define ACD_MASK_ACT_CLK 8'hF4
`define ACD_MASK_LIM_ROUTE 8'hF0
`define ACD_MASK_GAIN_COMP 8'hFF
`define ACD_MASK_PLIM0 8'hFC
`define ACD_READ_ZERO 8'h00

// ********************************
// field positions
// ********************************
`define ACD_CLK_SRC_HI 7
`define ACD_CLK_SRC_LO 6
`define ACD_EXT_RATE_HI 5
`define ACD_EXT_RATE_LO 4
`define ACD_PH1_BIT 2
`define ACD_LIM_DET_HI 7
`define ACD_LIM_DET_LO 6
`define ACD_LIM_APP_HI 5
`define ACD_LIM_APP_LO 4
`define ACD_AGC_HI 7
`define ACD_AGC_LO 4
`define ACD_DRC_HI 3
`define ACD_DRC_LO 0
`define ACD_PLIM_EN_BIT 7
`define ACD_PLIM_ATT_HI 6
`define ACD_PLIM_ATT_LO 4
`define ACD_PLIM_SRC_BIT 3
`define ACD_PLIM_REC_BIT 2

// ********************************
// external activity clock rates in kHz
// ********************************
`define ACD_EXT_KHZ_0 15'h6000
`define ACD_EXT_KHZ_1 15'h1800
`define ACD_EXT_KHZ_2 15'h3000
`define ACD_EXT_KHZ_3 15'h4800

// ********************************
// supply limiter
// ********************************
`define ACD_ATT_NONE 3'h0
`define ACD_SAR_W 8
`define ACD_SAR_LUT_HI 7
`define ACD_SAR_LUT_LO 5

`endif

// ===== inc/acd_pkg.sv
package acd_pkg;

  typedef enum logic [1:0] {
    ACD_CLK_OSC,
    ACD_CLK_BITCLK,
    ACD_CLK_SECONDARY,
    ACD_CLK_CUSTOM
  } acd_clk_src_t;

  typedef enum logic [1:0] {
    ACD_DET_MAX,
    ACD_DET_CH1,
    ACD_DET_CH0,
    ACD_DET_AVG
  } acd_det_src_t;

  typedef enum logic [1:0] {
    ACD_APP_BOTH,
    ACD_APP_CH1,
    ACD_APP_CH0,
    ACD_APP_NONE
  } acd_app_sel_t;

  typedef struct packed {
    logic enable;
    logic [2:0] attenuation;
    logic analog_source;
    logic recover;
  } acd_plim_cfg_t;

  typedef struct packed {
    logic [3:0] auto_gain;
    logic [3:0] compressor;
  } acd_chan_en_t;

endpackage

// ===== rtl/acd_plim.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"

module acd_plim (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire acd_pkg::acd_plim_cfg_t cfg,
  // supply sense
  input wire logic gpio_low_supply,
  input wire logic [`ACD_SAR_W-1:0] sar_data,
  input wire logic sar_valid,
  // result
  output logic [2:0] attenuation
);

  logic [2:0] target;
  logic [2:0] lut_att;
  logic [2:0] next_attenuation;

  // ********************************
  // target attenuation
  // ********************************
  // lower supply reading means deeper cut; top bits inverted keeps the table tiny
  assign lut_att = ~sar_data[`ACD_SAR_LUT_HI:`ACD_SAR_LUT_LO];

  always_comb begin
    if (cfg.analog_source) begin
      target = sar_valid ? lut_att : attenuation;
    end else begin
      target = gpio_low_supply ? cfg.attenuation : `ACD_ATT_NONE;
    end
  end

  always_comb begin
    if (!cfg.enable) begin
      next_attenuation = `ACD_ATT_NONE;
    end else if (cfg.recover) begin
      next_attenuation = target;
    end else begin
      // no recovery: hold or deepen only
      next_attenuation = (target > attenuation) ? target : attenuation;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      attenuation <= `ACD_ATT_NONE;
    end else begin
      attenuation <= next_attenuation;
    end
  end

endmodule
`default_nettype wire

// ===== tb/acd_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"

module acd_regs_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register access
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // activity clocking and detection
  input wire acd_pkg::acd_clk_src_t ACT_CLK_SOURCE,
  input wire logic ACT_CLK_USE_OSC,
  input wire logic ACT_CLK_USE_BITCLK,
  input wire logic ACT_CLK_USE_SECONDARY,
  input wire logic ACT_CLK_USE_CUSTOM,
  input wire logic [14:0] ACT_EXT_CLK_KHZ,
  input wire logic JACK_COMPARATOR,
  input wire logic PHASE_ONE_DETECT_ENABLE,
  input wire logic PHASE_ONE_TRIGGER,
  // limiter and dynamics
  input wire logic SAMPLE_VALID,
  input wire logic LIMITER_DETECT_VALID,
  input wire logic LIMITER_APPLY_CH0,
  input wire logic LIMITER_APPLY_CH1,
  input wire logic [3:0] AUTO_GAIN_CHANNEL_ENABLE,
  input wire logic [3:0] COMPRESSOR_CHANNEL_ENABLE,
  input wire logic SUPPLY_LIMITER_ENABLE,
  input wire logic [2:0] SUPPLY_LIMITER_ATTENUATION
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // ********
  // helpers
  // ********
  // delayed copies, so write and read checks look at last cycle's request
  logic [7:0] wd_q;
  logic [7:0] ad_q;
  always_ff @(posedge CLK) begin
    wd_q <= REG_WDATA;
    ad_q <= REG_ADDR;
  end

  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h20: msk = 8'hF4;
      8'h23: msk = 8'hF0;
      8'h24: msk = 8'hFF;
      8'h2B: msk = 8'hFC;
      default: msk = 8'h00;
    endcase
  endfunction

  function automatic logic [14:0] kz(input logic [1:0] r);
    case (r)
      2'h0: kz = 15'h6000;
      2'h1: kz = 15'h1800;
      2'h2: kz = 15'h3000;
      default: kz = 15'h4800;
    endcase
  endfunction

  // ********
  // assertions
  // ********
  a_clk_onehot: assert property (
    {ACT_CLK_USE_CUSTOM, ACT_CLK_USE_SECONDARY, ACT_CLK_USE_BITCLK, ACT_CLK_USE_OSC}
    == 4'h1 << ACT_CLK_SOURCE) else $error("clock source decode wrong");
  a_clk_src_write: assert property (REG_WR && REG_ADDR == 8'h20 |=>
    ACT_CLK_SOURCE == wd_q[7:6] && PHASE_ONE_DETECT_ENABLE == wd_q[2])
    else $error("clock source write not applied");
  a_ext_rate: assert property (REG_WR && REG_ADDR == 8'h20 |=>
    ACT_EXT_CLK_KHZ == kz(wd_q[5:4])) else $error("external rate wrong");
  a_phase_trigger: assert property (
    PHASE_ONE_DETECT_ENABLE && JACK_COMPARATOR |=> PHASE_ONE_TRIGGER)
    else $error("phase one trigger missing");
  a_detect_valid: assert property (SAMPLE_VALID |=> LIMITER_DETECT_VALID)
    else $error("detector sample not presented");
  a_apply_route: assert property (REG_WR && REG_ADDR == 8'h23 |=>
    {LIMITER_APPLY_CH1, LIMITER_APPLY_CH0} == ~wd_q[5:4]) else $error("apply route wrong");
  a_gain_enables: assert property (REG_WR && REG_ADDR == 8'h24 |=>
    AUTO_GAIN_CHANNEL_ENABLE == {wd_q[4], wd_q[5], wd_q[6], wd_q[7]} &&
    COMPRESSOR_CHANNEL_ENABLE == {wd_q[0], wd_q[1], wd_q[2], wd_q[3]})
    else $error("channel enables wrong");
  a_read_reserved: assert property (REG_RD |=> REG_RVALID &&
    (REG_RDATA & ~msk(ad_q)) == 8'h00) else $error("read answer wrong");
  a_plim_off: assert property (
    !SUPPLY_LIMITER_ENABLE |=> SUPPLY_LIMITER_ATTENUATION == 3'h0)
    else $error("attenuation while disabled");

  c_read: cover property (REG_RD ##1 REG_RVALID);
  c_trigger: cover property (PHASE_ONE_TRIGGER);
  c_detect: cover property (LIMITER_DETECT_VALID);
endmodule

bind acd_regs acd_regs_monitor i_acd_regs_monitor (
  .CLK(CLK), .NRST(NRST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .ACT_CLK_SOURCE(ACT_CLK_SOURCE), .ACT_CLK_USE_OSC(ACT_CLK_USE_OSC),
  .ACT_CLK_USE_BITCLK(ACT_CLK_USE_BITCLK), .ACT_CLK_USE_SECONDARY(ACT_CLK_USE_SECONDARY),
  .ACT_CLK_USE_CUSTOM(ACT_CLK_USE_CUSTOM), .ACT_EXT_CLK_KHZ(ACT_EXT_CLK_KHZ),
  .JACK_COMPARATOR(JACK_COMPARATOR), .PHASE_ONE_DETECT_ENABLE(PHASE_ONE_DETECT_ENABLE),
  .PHASE_ONE_TRIGGER(PHASE_ONE_TRIGGER), .SAMPLE_VALID(SAMPLE_VALID),
  .LIMITER_DETECT_VALID(LIMITER_DETECT_VALID), .LIMITER_APPLY_CH0(LIMITER_APPLY_CH0),
  .LIMITER_APPLY_CH1(LIMITER_APPLY_CH1), .AUTO_GAIN_CHANNEL_ENABLE(AUTO_GAIN_CHANNEL_ENABLE),
  .COMPRESSOR_CHANNEL_ENABLE(COMPRESSOR_CHANNEL_ENABLE),
  .SUPPLY_LIMITER_ENABLE(SUPPLY_LIMITER_ENABLE),
  .SUPPLY_LIMITER_ATTENUATION(SUPPLY_LIMITER_ATTENUATION)
);

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb_top;
  int error_cnt = 0;
  int checks_done = 0;
  logic CLK, NRST, REG_WR, REG_RD, REG_RVALID, JACK_COMPARATOR, PHASE_ONE_DETECT_ENABLE;
  logic ACT_CLK_USE_OSC, ACT_CLK_USE_BITCLK, ACT_CLK_USE_SECONDARY, ACT_CLK_USE_CUSTOM;
  logic PHASE_ONE_TRIGGER, SAMPLE_VALID, LIMITER_DETECT_VALID, LIMITER_APPLY_CH0;
  logic LIMITER_APPLY_CH1, GPIO_LOW_SUPPLY, SAR_VALID, SUPPLY_LIMITER_ENABLE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, SAR_DATA;
  logic [14:0] ACT_EXT_CLK_KHZ;
  logic [3:0] AUTO_GAIN_CHANNEL_ENABLE, COMPRESSOR_CHANNEL_ENABLE;
  logic [2:0] SUPPLY_LIMITER_ATTENUATION;
  logic [1:0] v;
  logic [3:0] hot;
  acd_pkg::acd_clk_src_t ACT_CLK_SOURCE;
  logic signed [15:0] DAC_INPUT_CHANNEL_ZERO, DAC_INPUT_CHANNEL_ONE, LIMITER_DETECT_SAMPLE;
  logic [14:0] kt [4] = '{15'h6000, 15'h1800, 15'h3000, 15'h4800};
  // max, ch1, ch0, floored average of -8 and 3
  logic signed [15:0] de [4] = '{16'sh0003, 16'sh0003, -16'sh0008, -16'sh0003};

  acd_regs #(.SAMPLE_W(16)) i_acd_regs (
    .CLK(CLK), .NRST(NRST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .ACT_CLK_SOURCE(ACT_CLK_SOURCE), .ACT_CLK_USE_OSC(ACT_CLK_USE_OSC),
    .ACT_CLK_USE_BITCLK(ACT_CLK_USE_BITCLK), .ACT_CLK_USE_SECONDARY(ACT_CLK_USE_SECONDARY),
    .ACT_CLK_USE_CUSTOM(ACT_CLK_USE_CUSTOM), .ACT_EXT_CLK_KHZ(ACT_EXT_CLK_KHZ),
    .JACK_COMPARATOR(JACK_COMPARATOR), .PHASE_ONE_DETECT_ENABLE(PHASE_ONE_DETECT_ENABLE),
    .PHASE_ONE_TRIGGER(PHASE_ONE_TRIGGER), .SAMPLE_VALID(SAMPLE_VALID),
    .DAC_INPUT_CHANNEL_ZERO(DAC_INPUT_CHANNEL_ZERO),
    .DAC_INPUT_CHANNEL_ONE(DAC_INPUT_CHANNEL_ONE),
    .LIMITER_DETECT_SAMPLE(LIMITER_DETECT_SAMPLE), .LIMITER_DETECT_VALID(LIMITER_DETECT_VALID),
    .LIMITER_APPLY_CH0(LIMITER_APPLY_CH0), .LIMITER_APPLY_CH1(LIMITER_APPLY_CH1),
    .AUTO_GAIN_CHANNEL_ENABLE(AUTO_GAIN_CHANNEL_ENABLE),
    .COMPRESSOR_CHANNEL_ENABLE(COMPRESSOR_CHANNEL_ENABLE),
    .GPIO_LOW_SUPPLY(GPIO_LOW_SUPPLY), .SAR_DATA(SAR_DATA), .SAR_VALID(SAR_VALID),
    .SUPPLY_LIMITER_ENABLE(SUPPLY_LIMITER_ENABLE),
    .SUPPLY_LIMITER_ATTENUATION(SUPPLY_LIMITER_ATTENUATION)
  );

  assign hot = {ACT_CLK_USE_CUSTOM, ACT_CLK_USE_SECONDARY, ACT_CLK_USE_BITCLK, ACT_CLK_USE_OSC};

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // ********
  // bus tasks
  // ********
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(negedge CLK);
  endtask

  // read valid stands one cycle and read data holds until the next read, so look at them in that cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    `CHK("rvalid", 1'b1, REG_RVALID)
    `CHK("rdata", e, REG_RDATA)
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial begin
    {NRST, REG_WR, REG_RD, JACK_COMPARATOR, SAMPLE_VALID, GPIO_LOW_SUPPLY, SAR_VALID} = '0;
    {REG_ADDR, REG_WDATA, SAR_DATA} = '0;
    DAC_INPUT_CHANNEL_ZERO = -16'sh0008;
    DAC_INPUT_CHANNEL_ONE = 16'sh0003;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(negedge CLK);
    `CHK("osc", 1'b1, ACT_CLK_USE_OSC)
    `CHK("khz", 15'h6000, ACT_EXT_CLK_KHZ)
    `CHK("apply", 2'h3, {LIMITER_APPLY_CH1, LIMITER_APPLY_CH0})
    rd(8'h20, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h2B, 8'h00);
    $display("test reset done");
    // reserved bits always go out as zero; only the phase-one bit sits among them
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      wr(8'h20, {v, v, 4'h4});
      `CHK("src", v, ACT_CLK_SOURCE)
      `CHK("hot", 4'h1 << v, hot)
      `CHK("khz", kt[i], ACT_EXT_CLK_KHZ)
      `CHK("ph1", 1'b1, PHASE_ONE_DETECT_ENABLE)
      rd(8'h20, {v, v, 4'h4});
    end
    @(posedge CLK);
    JACK_COMPARATOR <= 1'b1;
    repeat (2) @(negedge CLK);
    `CHK("trig", 1'b1, PHASE_ONE_TRIGGER)
    wr(8'h20, 8'h00);
    @(negedge CLK);
    `CHK("trig", 1'b0, PHASE_ONE_TRIGGER)
    @(posedge CLK);
    JACK_COMPARATOR <= 1'b0;
    $display("test clock done");
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      wr(8'h23, {v, v, 4'h0});
      rd(8'h23, {v, v, 4'h0});
      `CHK("apply", ~v, {LIMITER_APPLY_CH1, LIMITER_APPLY_CH0})
      @(posedge CLK);
      SAMPLE_VALID <= 1'b1;
      @(posedge CLK);
      SAMPLE_VALID <= 1'b0;
      @(negedge CLK);
      `CHK("dvalid", 1'b1, LIMITER_DETECT_VALID)
      `CHK("detect", de[i], LIMITER_DETECT_SAMPLE)
    end
    $display("test limiter done");
    for (int k = 0; k < 8; k++) begin
      wr(8'h24, 8'h01 << k);
      `CHK("agc", (k > 3) ? 4'h1 << (7 - k) : 4'h0, AUTO_GAIN_CHANNEL_ENABLE)
      `CHK("drc", (k < 4) ? 4'h1 << (3 - k) : 4'h0, COMPRESSOR_CHANNEL_ENABLE)
    end
    wr(8'h21, 8'hFF);
    rd(8'h21, 8'h00);
    rd(8'h24, 8'h80);
    // reset in mid-run must clear what was written
    @(posedge CLK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    rd(8'h24, 8'h00);
    $display("test dynamics done");
    wr(8'h2B, 8'hB0);
    rd(8'h2B, 8'hB0);
    `CHK("plim_en", 1'b1, SUPPLY_LIMITER_ENABLE)
    @(posedge CLK);
    GPIO_LOW_SUPPLY <= 1'b1;
    repeat (3) @(negedge CLK);
    `CHK("att", 3'h3, SUPPLY_LIMITER_ATTENUATION)
    @(posedge CLK);
    GPIO_LOW_SUPPLY <= 1'b0;
    repeat (3) @(negedge CLK);
    `CHK("att", 3'h3, SUPPLY_LIMITER_ATTENUATION)
    wr(8'h2B, 8'hB4);
    repeat (2) @(negedge CLK);
    `CHK("att", 3'h0, SUPPLY_LIMITER_ATTENUATION)
    wr(8'h2B, 8'h8C);
    @(posedge CLK);
    SAR_DATA <= 8'h3F;
    SAR_VALID <= 1'b1;
    @(posedge CLK);
    SAR_VALID <= 1'b0;
    repeat (2) @(negedge CLK);
    `CHK("att", 3'h6, SUPPLY_LIMITER_ATTENUATION)
    wr(8'h2B, 8'h00);
    repeat (2) @(negedge CLK);
    `CHK("att", 3'h0, SUPPLY_LIMITER_ATTENUATION)
    $display("test supply done");
    close_out;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK);
    error_cnt++;
    close_out;
  end
endmodule

`default_nettype wire
